/* File: core/dep_control.v */
// data eeprom program and erase sequencer with unlock and latches
`timescale 1ns/100ps
`default_nettype none
`include "dep_defines.vh"
module dep_control #(
  parameter CYCLE_CYCLES = `DEP_CYCLE_CYCLES,
  parameter ADDR_W = 24,
  parameter DATA_W = 16
) (
  // clock and resets
  input wire clock,
  input wire rst,
  input wire por,
  input wire cycle_abort_reset,
  // core register writes
  input wire ctrl_write,
  input wire [15:0] ctrl_wdata,
  input wire key_write,
  input wire [7:0] key_wdata,
  input wire addr_low_write,
  input wire addr_high_write,
  input wire [15:0] addr_wdata,
  input wire flag_clear,
  // table writes
  input wire table_write,
  input wire [ADDR_W-1:0] table_addr,
  input wire [DATA_W-1:0] table_data,
  // register views
  output reg [15:0] nonvolatile_control_register,
  output wire [15:0] target_address_low,
  output wire [7:0] target_address_high,
  output reg completion_interrupt_flag,
  output wire busy,
  // array side
  output reg array_erase_word,
  output reg array_erase_block,
  output reg array_prog_word,
  output reg array_prog_block,
  output reg [ADDR_W-1:0] array_addr,
  output reg [3:0] array_latch_index,
  output wire [DATA_W-1:0] array_data
);
  // unlock states; the spare code falls back to idle on the next key or control write
  // cycle length counter is a full word so any sensible clock rate fits
  localparam ST_IDLE = 2'd0;
  localparam ST_KEY1 = 2'd1;
  localparam ST_ARMED = 2'd2;
  localparam CNT_W = 32;
  localparam [CNT_W-1:0] CYCLE_LAST = CYCLE_CYCLES - 1;

  // sequencer state, captured address and the running cycle's own copy of
  // the op code, kept apart from the register so later writes cannot touch it
  reg [1:0] unlock_state;
  reg [1:0] next_unlock_state;
  reg [ADDR_W-1:0] target_addr;
  reg [CNT_W-1:0] cycle_count;
  reg [6:0] cycle_op;
  reg running;
  reg start_ok;
  wire enable_now;
  wire start_req;
  wire [6:0] write_op;
  wire start_fire;
  wire cycle_done;
  wire abort_now;

  assign enable_now = nonvolatile_control_register[`DEP_BIT_ENABLE];
  // start requested only if enable was already set beforehand
  assign start_req = ctrl_write && ctrl_wdata[`DEP_BIT_START] && enable_now;
  assign busy = running;
  assign target_address_low = target_addr[15:0];
  assign target_address_high = target_addr[ADDR_W-1:16];
  // op field of the control write now on the bus
  assign write_op = ctrl_wdata[`DEP_OP_HI:`DEP_OP_LO];

  // the op field is all that tells the four cycles apart; enable is added
  // back so the compare is against the full control word
  function [15:0] full_cmd;
    input [6:0] op;
    begin
      full_cmd = {2'b01, 7'h00, op};
    end
  endfunction

  // single word erase
  function is_word_erase;
    input [6:0] op;
    begin
      is_word_erase = (full_cmd(op) == `DEP_CMD_WORD_ERASE);
    end
  endfunction

  // whole block erase
  function is_block_erase;
    input [6:0] op;
    begin
      is_block_erase = (full_cmd(op) == `DEP_CMD_BLOCK_ERASE);
    end
  endfunction

  // one word from its latch
  function is_word_prog;
    input [6:0] op;
    begin
      is_word_prog = (full_cmd(op) == `DEP_CMD_WORD_PROG);
    end
  endfunction

  // all sixteen latches in one cycle
  function is_block_prog;
    input [6:0] op;
    begin
      is_block_prog = (full_cmd(op) == `DEP_CMD_BLOCK_PROG);
    end
  endfunction

  // decide whether an operation code names a supported cycle; anything
  // else is refused so a stray code cannot leave start stuck high
  function op_valid;
    input [6:0] op;
    begin
      op_valid = is_word_erase(op) || is_block_erase(op) || is_word_prog(op) ||
                 is_block_prog(op);
    end
  endfunction

  // a start is taken only from the armed key state with a known op
  assign start_fire = start_ok && op_valid(write_op);
  // last counted edge of a cycle; start, busy and flag all move on it
  assign cycle_done = running && (cycle_count == CYCLE_LAST);
  // an outside reset only matters while a cycle is under way
  assign abort_now = cycle_abort_reset && running;

  // unlock sequencer: any stray key or control write drops to idle
  // key writes win over a control write in the same cycle, so a start can
  // only follow a clean 0x55, 0xaa pair with nothing in between; the armed
  // state is spent by the very next control write, taken or not
  always @* begin
    next_unlock_state = unlock_state;
    start_ok = 1'b0;
    if (key_write) begin
      if (unlock_state == ST_IDLE && key_wdata == `DEP_KEY_FIRST) begin
        next_unlock_state = ST_KEY1;
      end else if (unlock_state == ST_KEY1 && key_wdata == `DEP_KEY_SECOND) begin
        next_unlock_state = ST_ARMED;
      end else begin
        next_unlock_state = ST_IDLE;
      end
    end else if (ctrl_write) begin
      next_unlock_state = ST_IDLE;
      case (unlock_state)
        ST_ARMED: begin
          start_ok = start_req && !running;
        end
        default: begin
          start_ok = 1'b0;
        end
      endcase
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      unlock_state <= ST_IDLE;
    end else begin
      unlock_state <= next_unlock_state;
    end
  end

  // control register; the enable bit only ever follows software writes and por
  // start is set here and cleared only by the cycle end, an abort or por, never
  // by software, so a stray write of zero cannot cut a cell cycle short;
  // the error bit is the opposite case, set by hardware, cleared by software
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      nonvolatile_control_register <= `DEP_CTRL_RESET;
    end else if (por) begin
      nonvolatile_control_register <= `DEP_CTRL_RESET;
    end else begin
      if (ctrl_write) begin
        nonvolatile_control_register[`DEP_BIT_ENABLE] <= ctrl_wdata[`DEP_BIT_ENABLE];
        // op field frozen mid-cycle so the running cycle is untouched
        if (!running) begin
          nonvolatile_control_register[`DEP_OP_HI:`DEP_OP_LO] <=
            ctrl_wdata[`DEP_OP_HI:`DEP_OP_LO];
        end
        // error flag is software clearable only
        if (!ctrl_wdata[`DEP_BIT_ERROR]) begin
          nonvolatile_control_register[`DEP_BIT_ERROR] <= 1'b0;
        end
      end
      if (start_fire) begin
        nonvolatile_control_register[`DEP_BIT_START] <= 1'b1;
      end else if (cycle_done) begin
        nonvolatile_control_register[`DEP_BIT_START] <= 1'b0;
      end
      if (abort_now) begin
        nonvolatile_control_register[`DEP_BIT_START] <= 1'b0;
        nonvolatile_control_register[`DEP_BIT_ERROR] <= 1'b1;
      end
    end
  end

  // cycle timer runs on its own; the core never waits on it
  // the count is a fixed stand-in for the cell time, which really drifts
  // with supply and temperature; a user who needs margin raises CYCLE_CYCLES
  // an abort while idle is ignored so start bit and timer agree, except after a por, which clears start but leaves running set
  // op strobes last one cycle and are meant for the array's own sequencer
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      running <= 1'b0;
      cycle_count <= {CNT_W{1'b0}};
      cycle_op <= 7'h00;
      array_erase_word <= 1'b0;
      array_erase_block <= 1'b0;
      array_prog_word <= 1'b0;
      array_prog_block <= 1'b0;
    end else begin
      array_erase_word <= 1'b0;
      array_erase_block <= 1'b0;
      array_prog_word <= 1'b0;
      array_prog_block <= 1'b0;
      if (abort_now) begin
        running <= 1'b0;
        cycle_count <= {CNT_W{1'b0}};
      end else if (!running) begin
        if (start_fire) begin
          running <= 1'b1;
          cycle_count <= {CNT_W{1'b0}};
          cycle_op <= write_op;
          array_erase_word <= is_word_erase(write_op);
          array_erase_block <= is_block_erase(write_op);
          array_prog_word <= is_word_prog(write_op);
          array_prog_block <= is_block_prog(write_op);
        end
      end else if (cycle_count == CYCLE_LAST) begin
        running <= 1'b0;
      end else begin
        cycle_count <= cycle_count + 32'h00000001;
      end
    end
  end

  // completion flag: set beats clear in the same cycle
  // a clear landing on the completing edge is dropped on purpose: losing
  // the completion event would leave software polling forever
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      completion_interrupt_flag <= 1'b0;
    end else if (cycle_done && !abort_now) begin
      completion_interrupt_flag <= 1'b1;
    end else if (flag_clear) begin
      completion_interrupt_flag <= 1'b0;
    end
  end

  // address register: software load or last table write; kept on abort
  // frozen while a cycle runs so the array sees one stable target; an abort
  // leaves it alone so software can read back which word was hit
  // table writes win over direct loads, matching the last-access capture
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      target_addr <= {ADDR_W{1'b0}};
    end else if (!running) begin
      if (table_write) begin
        target_addr <= table_addr;
      end else if (addr_low_write) begin
        target_addr[15:0] <= addr_wdata;
      end else if (addr_high_write) begin
        target_addr[ADDR_W-1:16] <= addr_wdata[7:0];
      end
    end
  end

  // array address and latch walk during a cycle
  // word cycles present the latch picked by the target address; a block
  // program steps through all sixteen, one latch per clock, wrapping round
  // the walk starts at the captured index, the last latch loaded
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      array_addr <= {ADDR_W{1'b0}};
      array_latch_index <= 4'h0;
    end else if (!running) begin
      array_addr <= target_addr;
      array_latch_index <= target_addr[4:1];
    end else if (is_block_prog(cycle_op)) begin
      // block program presents every latch in turn
      array_latch_index <= array_latch_index + 4'h1;
    end
  end

  // latch bank; table writes never reach the array directly
  // loads are refused while a cycle runs: the array may still be reading
  // the bank and a new word would tear the block
  dep_latches #(
    .DATA_W(DATA_W),
    .DEPTH(`DEP_LATCHES),
    .IDX_W(4)
  ) u_latches (
    .clock(clock),
    .rst(rst),
    .load(table_write && !running),
    .load_index(table_addr[4:1]),
    .load_data(table_data),
    .read_index(array_latch_index),
    .read_data(array_data)
  );
endmodule // dep_control
`default_nettype wire

/* File: core/dep_defines.vh */
// constants for the data eeprom program and erase controller
`ifndef DEP_DEFINES_VH
`define DEP_DEFINES_VH
// control register bit positions
`define DEP_BIT_START 15
`define DEP_BIT_ENABLE 14
`define DEP_BIT_ERROR 13
`define DEP_OP_HI 6
`define DEP_OP_LO 0
// control register reset value
`define DEP_CTRL_RESET 16'h0000
// unlock key values
`define DEP_KEY_FIRST 8'h55
`define DEP_KEY_SECOND 8'haa
// operation codes with program-enable set, start clear
`define DEP_CMD_WORD_ERASE 16'h4044
`define DEP_CMD_BLOCK_ERASE 16'h4045
`define DEP_CMD_WORD_PROG 16'h4004
`define DEP_CMD_BLOCK_PROG 16'h400a
// cell cycle time
`define DEP_CYCLE_US 2000
`define DEP_CLOCK_MHZ 250
`define DEP_CYCLE_CYCLES (`DEP_CYCLE_US * `DEP_CLOCK_MHZ)
// write latch count
`define DEP_LATCHES 16
`endif

/* File: core/dep_latches.v */
// sixteen-word write latch bank loaded by table writes
`timescale 1ns/100ps
`default_nettype none
module dep_latches #(
  parameter DATA_W = 16,
  parameter DEPTH = 16,
  parameter IDX_W = 4
) (
  // clock and reset
  input wire clock,
  input wire rst,
  // load side
  input wire load,
  input wire [IDX_W-1:0] load_index,
  input wire [DATA_W-1:0] load_data,
  // read side
  input wire [IDX_W-1:0] read_index,
  output wire [DATA_W-1:0] read_data
);
  reg [DATA_W-1:0] mem [0:DEPTH-1];
  integer i;

  // latches load from table writes only, never the array directly
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {DATA_W{1'b0}};
      end
    end else if (load) begin
      mem[load_index] <= load_data;
    end
  end

  assign read_data = mem[read_index];
endmodule // dep_latches
`default_nettype wire

/* File: test/dep_control_asserts.sv */
// port checker for the eeprom program and erase sequencer
`timescale 1ns/100ps
`default_nettype none
module dep_chk #(
  parameter int CYCLE_CYCLES = 20
) (
  // clock and resets
  input wire clock,
  input wire rst,
  input wire por,
  input wire cycle_abort_reset,
  // core writes
  input wire ctrl_write,
  input wire [15:0] ctrl_wdata,
  input wire key_write,
  input wire [7:0] key_wdata,
  input wire flag_clear,
  input wire table_write,
  input wire [23:0] table_addr,
  // views and array strobes
  input wire [15:0] nonvolatile_control_register,
  input wire [15:0] target_address_low,
  input wire [7:0] target_address_high,
  input wire completion_interrupt_flag,
  input wire busy,
  input wire array_erase_word,
  input wire array_erase_block,
  input wire array_prog_word,
  input wire array_prog_block
);
  // short views of the control register
  wire [15:0] ncr = nonvolatile_control_register;
  wire [6:0] op = ncr[6:0];
  wire start_wr = ctrl_write && ctrl_wdata[15] && ncr[14];
  int unsigned run_n;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // edges seen with start high; an early or late end shows as a wrong count
  always @(posedge clock or posedge rst) begin
    if (rst)
      run_n <= 0;
    else
      run_n <= ncr[15] ? run_n + 1 : 0;
  end
  sequence s_unlock;
    key_write && key_wdata == 8'h55 ##1 key_write && key_wdata == 8'haa ##1 start_wr && !busy
      && (ctrl_wdata[6:0] inside {7'h44, 7'h45, 7'h04, 7'h0a});
  endsequence
  property p_go;
    s_unlock |=> ncr[15] && busy;
  endproperty
  a_go: assert property (p_go) else $error("no start after unlock");
  property p_start;
    $rose(ncr[15]) |-> $past(start_wr) && $past(key_write, 2) && $past(key_wdata, 2) == 8'haa;
  endproperty
  a_start: assert property (p_start) else $error("start without unlock");
  property p_en;
    $fell(ncr[14]) |-> $past(por) || ($past(ctrl_write) && !$past(ctrl_wdata[14]));
  endproperty
  a_en: assert property (p_en) else $error("enable cleared by itself");
  property p_len;
    $fell(ncr[15]) && !$past(cycle_abort_reset) |-> run_n == CYCLE_CYCLES && completion_interrupt_flag;
  endproperty
  a_len: assert property (p_len) else $error("bad cycle length");
  property p_flag;
    $fell(completion_interrupt_flag) |-> $past(flag_clear);
  endproperty
  a_flag: assert property (p_flag) else $error("flag dropped");
  property p_kind;
    $rose(ncr[15]) |-> {array_erase_word, array_erase_block, array_prog_word, array_prog_block}
      == {op == 7'h44, op == 7'h45, op == 7'h04, op == 7'h0a};
  endproperty
  a_kind: assert property (p_kind) else $error("wrong operation");
  property p_addr;
    table_write && !busy |=> {target_address_high, target_address_low} == $past(table_addr);
  endproperty
  a_addr: assert property (p_addr) else $error("address not captured");
  property p_abort;
    cycle_abort_reset && ncr[15] |=> ncr[13] && !ncr[15] && $stable(target_address_low);
  endproperty
  a_abort: assert property (p_abort) else $error("abort not flagged");
endmodule // dep_chk
bind dep_control dep_chk #(.CYCLE_CYCLES(CYCLE_CYCLES)) u_chk (
  .clock(clock), .rst(rst), .por(por), .cycle_abort_reset(cycle_abort_reset),
  .ctrl_write(ctrl_write), .ctrl_wdata(ctrl_wdata), .key_write(key_write),
  .key_wdata(key_wdata), .flag_clear(flag_clear), .table_write(table_write),
  .table_addr(table_addr), .nonvolatile_control_register(nonvolatile_control_register),
  .target_address_low(target_address_low), .target_address_high(target_address_high),
  .completion_interrupt_flag(completion_interrupt_flag), .busy(busy),
  .array_erase_word(array_erase_word), .array_erase_block(array_erase_block),
  .array_prog_word(array_prog_word), .array_prog_block(array_prog_block)
);
`default_nettype wire

/* File: test/dep_core_model.sv */
// processor core model issuing register and table writes
`timescale 1ns/100ps
`default_nettype none
module dep_core (
  // clock
  input wire logic clock,
  // strobes: ctrl, key, addr low, addr high, table, flag clear
  output var logic [5:0] stb,
  // shared write data and table address
  output var logic [15:0] dat,
  output var logic [23:0] adr
);
  initial begin
    stb = 6'h00;
    dat = 16'h0000;
    adr = 24'h000000;
  end
  // strobe held until idle, so writes can run back to back
  task automatic put(input int k, input logic [15:0] d, input logic [23:0] a);
    @(negedge clock);
    stb = 6'h01 << k;
    dat = d;
    adr = a;
  endtask
  // released lines show the inverse, never a stale value
  task automatic idle();
    @(negedge clock);
    stb = 6'h00;
    dat = ~dat;
    adr = ~adr;
  endtask
  // enable goes in an earlier write than start
  task automatic go(input logic [15:0] cmd);
    put(0, cmd, adr);
    put(1, 16'h0055, adr);
    put(1, 16'h00aa, adr);
    put(0, cmd | 16'h8000, adr);
    idle();
  endtask
endmodule // dep_core
`default_nettype wire

/* File: test/tb_data_eeprom_program_erase_control.sv */
// self-checking bench for the eeprom sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_data_eeprom_program_erase_control;
  localparam int RUN = 20;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b0;
  logic cycle_abort_reset = 1'b0;
  wire [5:0] stb;
  wire [15:0] dat;
  wire [23:0] adr;
  wire [15:0] ncr;
  wire [15:0] adr_lo;
  wire flag;
  wire [15:0] arr_data;
  wire [3:0] arr_idx;
  logic [15:0] lat [16];
  int err_total = 0;
  int samples_checked = 0;
  int seed = 32'h0f6b;
  logic [23:0] base;
  logic [15:0] ops [4] = '{16'h4044, 16'h4004, 16'h400a, 16'h4045};
  // 4 ns core clock
  initial begin
    forever #2 clock = ~clock;
  end
  dep_core core (.clock(clock), .stb(stb), .dat(dat), .adr(adr));
  dep_control #(.CYCLE_CYCLES(RUN)) DUT (
    .clock(clock), .rst(rst), .por(por), .cycle_abort_reset(cycle_abort_reset),
    .ctrl_write(stb[0]), .ctrl_wdata(dat), .key_write(stb[1]), .key_wdata(dat[7:0]),
    .addr_low_write(stb[2]), .addr_high_write(stb[3]), .addr_wdata(dat), .flag_clear(stb[5]),
    .table_write(stb[4]), .table_addr(adr), .table_data(dat),
    .nonvolatile_control_register(ncr), .target_address_low(adr_lo), .target_address_high(),
    .completion_interrupt_flag(flag), .busy(), .array_erase_word(), .array_erase_block(),
    .array_prog_word(), .array_prog_block(), .array_addr(), .array_latch_index(arr_idx),
    .array_data(arr_data));
  task automatic conclude();
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // start and error bits drop at the end, the rest stays as written
  function automatic logic [15:0] done_val(input logic [15:0] cmd);
    return cmd & 16'h5fff;
  endfunction
  // bounded poll of the flag; it must hold until cleared
  task automatic finish_op();
    int n;
    n = 0;
    while (flag !== 1'b1 && n < 4 * RUN) begin
      @(negedge clock);
      n++;
    end
    if (n == 4 * RUN) begin
      err_total++;
      conclude();
    end
    repeat (3) @(negedge clock);
    chk({15'h0000, flag}, 16'h0001);
    core.put(5, dat, adr);
    core.idle();
    chk({15'h0000, flag}, 16'h0000);
  endtask
  initial begin
    repeat (16) @(negedge clock);
    rst = 1'b0;
    chk(ncr, 16'h0000);
    // refused: enable never set, then a ctrl write breaking the key pair
    core.go(16'h0044);
    chk({15'h0000, ncr[15]}, 16'h0000);
    // enable and start in one write after a clean key pair
    core.put(1, 16'h0055, adr);
    core.put(1, 16'h00aa, adr);
    core.put(0, 16'hc044, adr);
    core.idle();
    chk({15'h0000, ncr[15]}, 16'h0000);
    core.put(0, 16'h4044, adr);
    core.put(1, 16'h0055, adr);
    core.put(0, 16'h4044, adr);
    core.put(1, 16'h00aa, adr);
    core.put(0, 16'hc044, adr);
    core.idle();
    chk({15'h0000, ncr[15]}, 16'h0000);
    // random block into the latches, last address captured
    base = 24'h7ff000 | {12'h000, 7'($random(seed)), 5'h00};
    for (int i = 0; i < 16; i++) begin
      lat[i] = 16'($random(seed));
      core.put(4, lat[i], base + 24'(2 * i));
    end
    core.idle();
    chk(adr_lo, base[15:0] + 16'h001e);
    foreach (ops[j]) begin
      core.go(ops[j]);
      if (j == 1) begin
        core.put(0, 16'h0004, adr);
        core.idle();
      end
      // block program walks the latches from the last one loaded
      if (j == 2) begin
        chk(arr_data, lat[15]);
        for (int k = 0; k < 7; k++) begin
          @(negedge clock);
          chk(arr_data, lat[k]);
        end
        core.go(ops[j]);
      end
      finish_op();
      chk(ncr, done_val(j == 1 ? 16'h0004 : ops[j]));
    end
    // abort mid erase keeps the address
    core.put(2, base[15:0], adr);
    core.put(3, {8'h00, base[23:16]}, adr);
    core.go(16'h4044);
    cycle_abort_reset = 1'b1;
    @(negedge clock);
    cycle_abort_reset = 1'b0;
    chk(ncr, 16'h6044);
    chk(adr_lo, base[15:0]);
    por = 1'b1;
    @(negedge clock);
    por = 1'b0;
    chk(ncr, 16'h0000);
    conclude();
  end
endmodule // tb_data_eeprom_program_erase_control
`default_nettype wire
